// ---- rtl/tzc_pkg.sv ----
// shared constants, types and register map for the triple-zone conversion controller
package tzc_pkg;

	// ----------------------------------------
	// register byte addresses (APB, one word each)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONFIG      = 8'h00;
	localparam logic [7:0] ADDR_RATE        = 8'h04;
	localparam logic [7:0] ADDR_ONE_SHOT    = 8'h08;
	localparam logic [7:0] ADDR_BETA        = 8'h0c;
	localparam logic [7:0] ADDR_STATUS      = 8'h10;
	localparam logic [7:0] ADDR_INT_HI      = 8'h14;
	localparam logic [7:0] ADDR_INT_LO      = 8'h18;
	localparam logic [7:0] ADDR_EXT1_HI     = 8'h1c;
	localparam logic [7:0] ADDR_EXT1_LO     = 8'h20;
	localparam logic [7:0] ADDR_EXT2_HI     = 8'h24;
	localparam logic [7:0] ADDR_EXT2_LO     = 8'h28;
	localparam logic [7:0] ADDR_EXT1_XHI    = 8'h2c;
	localparam logic [7:0] ADDR_EXT1_XLO    = 8'h30;
	localparam logic [7:0] ADDR_EXT2_XHI    = 8'h34;
	localparam logic [7:0] ADDR_EXT2_XLO    = 8'h38;

	// ----------------------------------------
	// config register fields
	// ----------------------------------------
	localparam int CFG_RUN_BIT      = 0;
	localparam int CFG_HOTTER_BIT   = 1;
	localparam int CFG_AVG_DIS_BIT  = 2;
	localparam int CFG_MAXRES_BIT   = 3;
	localparam int CFG_SRC_EN_BIT   = 4;
	localparam logic [4:0] CFG_RESET = 5'h10;

	// ----------------------------------------
	// status register fields
	// ----------------------------------------
	localparam int ST_BUSY_BIT      = 0;
	localparam int ST_FAULT1_BIT    = 1;
	localparam int ST_FAULT2_BIT    = 2;
	localparam int ST_HOTTER_BIT    = 3;
	localparam int ST_BETA_ON_BIT   = 4;

	localparam logic [2:0] RATE_RESET  = 3'h0;
	localparam logic [2:0] RATE_MAX    = 3'h4;
	localparam logic [7:0] BETA_OFF    = 8'h07;

	// ----------------------------------------
	// result codes (11-bit)
	// ----------------------------------------
	localparam logic [10:0] CODE_FAULT   = 11'h400;
	localparam logic [10:0] CODE_LOW     = 11'h600;
	localparam logic [10:0] CODE_HIGH    = 11'h3ff;
	localparam logic [10:0] CODE_XHIGH   = 11'h3ff;
	localparam logic [10:0] RESULT_RESET = 11'h400;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ         = 200_000_000;
	localparam int BASE_SET_HZ    = 16;
	localparam int BASE_PERIOD    = CLK_HZ / BASE_SET_HZ;
	localparam int CONV_TIME_US   = 2000;
	localparam int CONV_CYCLES    = CONV_TIME_US * (CLK_HZ / 1_000_000);

	typedef enum logic [1:0] {
		TZC_CH_INT  = 2'h0,
		TZC_CH_EXT1 = 2'h1,
		TZC_CH_EXT2 = 2'h2
	} tzc_chan_t;

	// analog front-end request and answer
	typedef struct packed {
		logic      start;
		tzc_chan_t chan;
		logic [2:0] avg_factor;
		logic      src_en;
		logic      beta_en;
	} tzc_afe_req_t;

	typedef struct packed {
		logic        done;
		logic        fault;
		logic [13:0] temp;
	} tzc_afe_rsp_t;

	typedef struct packed {
		logic [10:0] norm;
		logic [10:0] ext;
	} tzc_fmt_t;

endpackage

// ---- rtl/tzc_format.sv ----
// converts a signed 0.125-degree reading into normal and extended 11-bit codes
`timescale 1ns/1ps
module tzc_format (
	input  wire logic [13:0]       temp,
	input  wire logic              fault,
	output tzc_pkg::tzc_fmt_t      fmt
);
	// temp: signed, 0.125-degree steps, range beyond both formats
	logic signed [13:0] t;
	logic signed [13:0] tx;

	always_comb begin
		t  = temp;
		tx = t - 14'sd512;
		fmt.norm = tzc_pkg::CODE_FAULT;
		fmt.ext  = tzc_pkg::CODE_FAULT;
		if (!fault) begin
			if (t <= -14'sd512)
				fmt.norm = tzc_pkg::CODE_LOW;
			else if (t >= 14'sd1023)
				fmt.norm = tzc_pkg::CODE_HIGH;
			else
				fmt.norm = t[10:0];
			// extended: 64-degree offset, clamp both ends
			if (t <= -14'sd512)
				fmt.ext = tzc_pkg::CODE_FAULT;
			else if (t >= 14'sd1535)
				fmt.ext = tzc_pkg::CODE_XHIGH;
			else
				fmt.ext = tx[10:0]; // plain two's complement once the offset is taken off
		end
	end
endmodule

// ---- rtl/tzc_rate_timer.sv ----
// free counter that marks the start of each conversion set at the chosen rate
`timescale 1ns/1ps
module tzc_rate_timer #(
	parameter int BASE_PERIOD = tzc_pkg::BASE_PERIOD
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [2:0] rate,
	output logic            tick
);
	// a rate code n gives 2**n sets per second; 16/s is the base period
	logic [31:0] cnt;
	logic [31:0] limit;

	always_comb begin
		limit = 32'(BASE_PERIOD) << (3'h4 - rate);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt  <= 32'h0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt  <= 32'h0;
			tick <= 1'b0;
		end else if (cnt >= limit - 32'h1) begin
			cnt  <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule

// ---- rtl/tzc_ctrl.sv ----
// conversion sequencer, result formatting and APB register file
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - one-shot write in standby runs one full set then returns to standby
// - normal run mode converts all channels repeatedly and refreshes results
// - hotter mode puts the larger external reading in zone two results
// - in hotter mode the hotter status bit shows which external zone read larger
// - equal readings clear hotter bit and each zone keeps its own result
// - set rate programmable from one to sixteen sets per second
// - averaging lengthens external measurements two or four times at same rate
// - factor: disabled 1x, enabled 2x or 4x by max resolution; rate limits
// - software may disable averaging for single-length external measurement
// - one-shot uses the averaging the selected rate would use
// - results split into high byte and top three bits of low byte
// - wider converter readings are clamped into an 11-bit result
// - external zones also give offset-by-64 extended results
// - normal and extended results kept apart, both updated every conversion
// - 0.125 steps, fault code 400h, normal range clamps at both ends
// - series resistance correction on by default, off when bit cleared
// - beta compensation off at reset, on for any value but 07h
// - standby at reset; no monitoring but registers still answer
// - diode fault sets zone fault bit and loads fault code
module tzc_ctrl #(
	parameter int BASE_PERIOD = tzc_pkg::BASE_PERIOD
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output tzc_pkg::tzc_afe_req_t     afe_req,
	input  wire tzc_pkg::tzc_afe_rsp_t afe_rsp
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [3:0] {
		TZC_ST_STANDBY = 4'b0001,
		TZC_ST_WAIT    = 4'b0010,
		TZC_ST_START   = 4'b0100,
		TZC_ST_CONVERT = 4'b1000
	} tzc_state_t;

	typedef struct packed {
		tzc_state_t         st;
		tzc_pkg::tzc_chan_t chan;
		logic               one_shot;
		logic [4:0]         cfg;
		logic [2:0]         rate;
		logic [7:0]         beta;
		logic               beta_en;
		logic               fault1;
		logic               fault2;
		logic               hotter;
		logic [10:0]        r_int;
		logic [10:0]        r_e1;
		logic [10:0]        r_e2;
		logic [10:0]        x_e1;
		logic [10:0]        x_e2;
		logic               e1_fault;
		logic [13:0]        e1_temp;
		logic [31:0]        prdata;
		logic               pready;
		logic               pslverr;
		tzc_pkg::tzc_afe_req_t afe_req;
	} tzc_regs_t;

	tzc_regs_t r;
	tzc_regs_t next_r;

	logic              tick;
	logic              run_mode;
	logic              hot_mode;
	tzc_pkg::tzc_fmt_t fmt_now;
	logic [2:0]        avg_factor;
	logic              acc;
	logic              wr;
	logic              rd_hit;
	logic [31:0]       rd_val;

	assign run_mode = r.cfg[tzc_pkg::CFG_RUN_BIT];
	assign hot_mode = r.cfg[tzc_pkg::CFG_HOTTER_BIT];
	assign acc      = psel && penable && !r.pready;
	assign wr       = acc && pwrite;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	tzc_rate_timer #(
		.BASE_PERIOD (BASE_PERIOD)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (run_mode),
		.rate    (r.rate),
		.tick    (tick)
	);

	tzc_format u_fmt (
		.temp  (afe_rsp.temp),
		.fault (afe_rsp.fault),
		.fmt   (fmt_now)
	);

	// ----------------------------------------
	// averaging factor
	// ----------------------------------------
	// one-shot uses the same table, so no separate path
	always_comb begin
		avg_factor = 3'h1;
		if (!r.cfg[tzc_pkg::CFG_AVG_DIS_BIT]) begin
			if (r.rate == 3'h4)
				avg_factor = 3'h1;
			else if (r.rate == 3'h3)
				avg_factor = 3'h2;
			else if (r.cfg[tzc_pkg::CFG_MAXRES_BIT])
				avg_factor = 3'h4;
			else
				avg_factor = 3'h2;
		end
	end

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0;
		unique case (paddr)
			tzc_pkg::ADDR_CONFIG:   rd_val = {27'h0, r.cfg};
			tzc_pkg::ADDR_RATE:     rd_val = {29'h0, r.rate};
			tzc_pkg::ADDR_ONE_SHOT: rd_val = 32'h0;
			tzc_pkg::ADDR_BETA:     rd_val = {24'h0, r.beta};
			tzc_pkg::ADDR_STATUS:   rd_val = {27'h0, r.beta_en, r.hotter, r.fault2,
				r.fault1, (r.st != TZC_ST_STANDBY)};
			tzc_pkg::ADDR_INT_HI:   rd_val = {24'h0, r.r_int[10:3]};
			tzc_pkg::ADDR_INT_LO:   rd_val = {24'h0, r.r_int[2:0], 5'h0};
			tzc_pkg::ADDR_EXT1_HI:  rd_val = {24'h0, r.r_e1[10:3]};
			tzc_pkg::ADDR_EXT1_LO:  rd_val = {24'h0, r.r_e1[2:0], 5'h0};
			tzc_pkg::ADDR_EXT2_HI:  rd_val = {24'h0, r.r_e2[10:3]};
			tzc_pkg::ADDR_EXT2_LO:  rd_val = {24'h0, r.r_e2[2:0], 5'h0};
			tzc_pkg::ADDR_EXT1_XHI: rd_val = {24'h0, r.x_e1[10:3]};
			tzc_pkg::ADDR_EXT1_XLO: rd_val = {24'h0, r.x_e1[2:0], 5'h0};
			tzc_pkg::ADDR_EXT2_XHI: rd_val = {24'h0, r.x_e2[10:3]};
			tzc_pkg::ADDR_EXT2_XLO: rd_val = {24'h0, r.x_e2[2:0], 5'h0};
			default:                rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.pready  = acc;
		next_r.pslverr = acc && !rd_hit;
		next_r.prdata  = (acc && !pwrite && rd_hit) ? rd_val : 32'h0;
		next_r.afe_req.start = 1'b0;
		next_r.afe_req.src_en = r.cfg[tzc_pkg::CFG_SRC_EN_BIT];
		next_r.afe_req.beta_en = r.beta_en;

		// register writes
		if (wr && rd_hit) begin
			unique case (paddr)
				tzc_pkg::ADDR_CONFIG: next_r.cfg = pwdata[4:0];
				tzc_pkg::ADDR_RATE: begin
					if (pwdata[2:0] <= tzc_pkg::RATE_MAX)
						next_r.rate = pwdata[2:0];
				end
				tzc_pkg::ADDR_ONE_SHOT: begin
					if (r.st == TZC_ST_STANDBY && !run_mode)
						next_r.one_shot = 1'b1;
				end
				tzc_pkg::ADDR_BETA: begin
					next_r.beta    = pwdata[7:0];
					next_r.beta_en = (pwdata[7:0] != tzc_pkg::BETA_OFF);
				end
				default: ;
			endcase
		end

		// sequencer
		unique case (r.st)
			TZC_ST_STANDBY: begin
				// monitoring stopped, registers still served
				if (run_mode || r.one_shot) begin
					next_r.st   = TZC_ST_START;
					next_r.chan = tzc_pkg::TZC_CH_INT;
				end
			end
			TZC_ST_WAIT: begin
				// low-power wait between sets
				if (!run_mode)
					next_r.st = TZC_ST_STANDBY;
				else if (tick) begin
					next_r.st   = TZC_ST_START;
					next_r.chan = tzc_pkg::TZC_CH_INT;
				end
			end
			TZC_ST_START: begin
				next_r.afe_req.start = 1'b1;
				next_r.afe_req.chan  = r.chan;
				next_r.afe_req.avg_factor =
					(r.chan == tzc_pkg::TZC_CH_INT) ? 3'h1 : avg_factor;
				next_r.st = TZC_ST_CONVERT;
			end
			TZC_ST_CONVERT: begin
				if (afe_rsp.done) begin
					// whole-word update at channel end keeps reads coherent
					unique case (r.chan)
						tzc_pkg::TZC_CH_INT: begin
							next_r.r_int = fmt_now.norm;
							next_r.chan  = tzc_pkg::TZC_CH_EXT1;
							next_r.st    = TZC_ST_START;
						end
						tzc_pkg::TZC_CH_EXT1: begin
							next_r.fault1   = afe_rsp.fault;
							next_r.r_e1     = fmt_now.norm;
							next_r.x_e1     = fmt_now.ext;
							next_r.e1_fault = afe_rsp.fault;
							next_r.e1_temp  = afe_rsp.temp;
							next_r.chan     = tzc_pkg::TZC_CH_EXT2;
							next_r.st       = TZC_ST_START;
						end
						default: begin
							next_r.fault2 = afe_rsp.fault;
							next_r.r_e2   = fmt_now.norm;
							next_r.x_e2   = fmt_now.ext;
							next_r.hotter = 1'b0;
							if (hot_mode && !afe_rsp.fault && !r.e1_fault &&
								$signed(r.e1_temp) > $signed(afe_rsp.temp)) begin
								next_r.r_e2   = r.r_e1;
								next_r.x_e2   = r.x_e1;
								next_r.hotter = 1'b1;
							end // equal or zone two larger keeps own
							next_r.one_shot = 1'b0;
							// set complete
							next_r.st = (run_mode) ? TZC_ST_WAIT : TZC_ST_STANDBY;
						end
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r          <= '0;
			r.st       <= TZC_ST_STANDBY;
			r.chan     <= tzc_pkg::TZC_CH_INT;
			r.cfg      <= tzc_pkg::CFG_RESET;
			r.rate     <= tzc_pkg::RATE_RESET;
			r.beta     <= tzc_pkg::BETA_OFF;
			r.r_int    <= tzc_pkg::RESULT_RESET;
			r.r_e1     <= tzc_pkg::RESULT_RESET;
			r.r_e2     <= tzc_pkg::RESULT_RESET;
			r.x_e1     <= tzc_pkg::RESULT_RESET;
			r.x_e2     <= tzc_pkg::RESULT_RESET;
			r.afe_req.avg_factor <= 3'h1;
			r.afe_req.src_en     <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign prdata  = r.prdata;
	assign pready  = r.pready;
	assign pslverr = r.pslverr;
	assign afe_req = r.afe_req;

endmodule

// ---- verif/tzc_ctrl_checker.sv ----
// port assertions for the conversion controller
`timescale 1ns/1ps
module tzc_ctrl_checker #(
	parameter int BASE_PERIOD = tzc_pkg::BASE_PERIOD
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire tzc_pkg::tzc_afe_req_t afe_req,
	input wire tzc_pkg::tzc_afe_rsp_t afe_rsp
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// channel of the last request, to check the order within a set
	logic [1:0] lc;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lc <= 2'h0;
		end else if (afe_req.start) begin
			lc <= afe_req.chan;
		end
	end
	apb_wait_a: assert property (
		psel && penable && !pready |=> pready) else $error("access not answered");
	ready_pulse_a: assert property (
		pready |=> !pready) else $error("ready held too long");
	idle_data_a: assert property (
		!pready |-> prdata == 32'h0) else $error("read data outside answer");
	err_ready_a: assert property (
		pslverr |-> pready) else $error("error without ready");
	start_pulse_a: assert property (
		afe_req.start |=> !afe_req.start) else $error("start longer than a cycle");
	int_single_a: assert property (
		afe_req.start && afe_req.chan == tzc_pkg::TZC_CH_INT |-> afe_req.avg_factor == 3'h1)
		else $error("internal zone averaged");
	avg_legal_a: assert property (
		afe_req.start |-> afe_req.avg_factor inside {3'h1, 3'h2, 3'h4})
		else $error("illegal averaging factor");
	ext1_next_a: assert property (
		afe_rsp.done && lc == 2'h0 |-> ##[1:4] (afe_req.start && afe_req.chan == 2'h1))
		else $error("zone one not next");
	ext2_next_a: assert property (
		afe_rsp.done && lc == 2'h1 |-> ##[1:4] (afe_req.start && afe_req.chan == 2'h2))
		else $error("zone two not next");
	reset_out_a: assert property (
		$rose(presetn) |-> afe_req.src_en && !afe_req.beta_en && !afe_req.start)
		else $error("front end controls wrong after reset");
	cover property (afe_req.start && afe_req.chan == 2'h2 && afe_req.avg_factor == 3'h4);
	cover property (pslverr);
	cover property (afe_rsp.done && afe_rsp.fault);
endmodule

// ---- verif/tzc_afe_model.sv ----
// behavioural front end answering each conversion request after a delay
`timescale 1ns/1ps
module tzc_afe_model #(
	parameter int LAT = 12
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire tzc_pkg::tzc_afe_req_t req,
	input  wire logic [2:0][13:0]      temps,
	input  wire logic [2:0]            faults,
	output tzc_pkg::tzc_afe_rsp_t      rsp
);
	int              n_starts;
	int              cnt;
	int              cyc;
	int              last_t;
	int              int_gap;
	logic            busy;
	logic            last_src;
	logic            last_beta;
	logic [1:0]      ch;
	logic [2:0][2:0] last_avg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp <= '0;
			busy <= 1'b0;
			n_starts <= 0;
			cyc <= 0;
		end else begin
			cyc <= cyc + 1;
			rsp.done <= 1'b0;
			// released lines invert every cycle instead of holding the last value
			rsp.temp <= ~rsp.temp;
			rsp.fault <= ~rsp.fault;
			if (req.start) begin
				busy <= 1'b1;
				ch <= req.chan;
				// longer integration answers slower
				cnt <= LAT * int'(req.avg_factor);
				n_starts <= n_starts + 1;
				last_avg[req.chan] <= req.avg_factor;
				last_src <= req.src_en;
				last_beta <= req.beta_en;
				if (req.chan == tzc_pkg::TZC_CH_INT) begin
					int_gap <= cyc - last_t;
					last_t <= cyc;
				end
			end else if (busy) begin
				if (cnt > 1) begin
					cnt <= cnt - 1;
				end else begin
					busy <= 1'b0;
					rsp.done <= 1'b1;
					rsp.temp <= temps[ch];
					rsp.fault <= faults[ch];
				end
			end
		end
	end
endmodule

// ---- verif/tzc_ctrl_tb.sv ----
// self-checking bench for the conversion controller
`timescale 1ns/1ps
module tzc_ctrl_tb;
	localparam int BP = 200;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, q;
	tzc_pkg::tzc_afe_req_t afe_req;
	tzc_pkg::tzc_afe_rsp_t afe_rsp;
	logic [2:0][13:0]      temps;
	logic [2:0]            faults;
	int                    failures, samples_checked, t;
	int                    hc [3][3] = '{'{400, 320, 1}, '{320, 320, 0}, '{240, 320, 0}};

	tzc_ctrl #(.BASE_PERIOD(BP)) tzc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .afe_req(afe_req), .afe_rsp(afe_rsp));
	tzc_afe_model tzc_afe_model_i (.pclk(pclk), .presetn(presetn), .req(afe_req),
		.temps(temps), .faults(faults), .rsp(afe_rsp));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) failures++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	task automatic zone(input logic [7:0] a, input logic [10:0] c);
		rd(a, {24'h0, c[10:3]});
		rd(a + 8'h04, {24'h0, c[2:0], 5'h0});
	endtask
	task automatic wait_sets(input int k);
		int n, g;
		n = 0;
		g = tzc_afe_model_i.n_starts + 3 * k;
		while ((tzc_afe_model_i.n_starts < g || tzc_afe_model_i.busy) && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) failures++;
		// results land the edge after the last answer
		repeat (4) @(posedge pclk);
	endtask
	task automatic one_shot;
		wr(tzc_pkg::ADDR_ONE_SHOT, 32'h1);
		wait_sets(1);
	endtask
	task automatic setz(input int a, input int b, input int c, input logic [2:0] f);
		temps <= {c[13:0], b[13:0], a[13:0]};
		faults <= f;
	endtask
	function automatic logic [10:0] nrm(input int v);
		return v <= -512 ? 11'h600 : (v >= 1023 ? 11'h3ff : v[10:0]);
	endfunction
	function automatic logic [10:0] xtd(input int v);
		return v <= -512 ? 11'h400 : (v >= 1535 ? 11'h3ff : 11'(v - 512));
	endfunction
	function automatic logic [31:0] av(input int r, input int m);
		return (m == 0 || r == 4) ? 32'h1 : ((m == 2 && r < 3) ? 32'h4 : 32'h2);
	endfunction
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		temps = '0;
		faults = 3'h0;
		failures = 0;
		samples_checked = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(tzc_pkg::ADDR_CONFIG, 32'h10);
		rd(tzc_pkg::ADDR_BETA, 32'h07);
		rd(tzc_pkg::ADDR_STATUS, 32'h0);
		zone(tzc_pkg::ADDR_EXT2_HI, 11'h400);
		apb(1'b0, 8'hfc, 32'h0);
		chk({31'h0, e}, 32'h1);
		repeat (300) @(posedge pclk);
		chk(tzc_afe_model_i.n_starts, 0);
		$display("reset test done");
		setz(200, 240, -80, 3'h0);
		one_shot();
		zone(tzc_pkg::ADDR_INT_HI, nrm(200));
		zone(tzc_pkg::ADDR_EXT1_HI, nrm(240));
		zone(tzc_pkg::ADDR_EXT2_HI, nrm(-80));
		zone(tzc_pkg::ADDR_EXT1_XHI, xtd(240));
		zone(tzc_pkg::ADDR_EXT2_XHI, xtd(-80));
		repeat (300) @(posedge pclk);
		chk(tzc_afe_model_i.n_starts, 3);
		$display("one-shot test done");
		wr(tzc_pkg::ADDR_CONFIG, 32'h0);
		wr(tzc_pkg::ADDR_BETA, 32'h0);
		setz(-600, 0, 1700, 3'h2);
		one_shot();
		zone(tzc_pkg::ADDR_INT_HI, 11'h600);
		zone(tzc_pkg::ADDR_EXT1_HI, 11'h400);
		zone(tzc_pkg::ADDR_EXT1_XHI, 11'h400);
		zone(tzc_pkg::ADDR_EXT2_HI, 11'h3ff);
		zone(tzc_pkg::ADDR_EXT2_XHI, 11'h3ff);
		rd(tzc_pkg::ADDR_STATUS, 32'h12);
		chk({31'h0, tzc_afe_model_i.last_src}, 32'h0);
		chk({31'h0, tzc_afe_model_i.last_beta}, 32'h1);
		wr(tzc_pkg::ADDR_BETA, 32'h07);
		rd(tzc_pkg::ADDR_STATUS, 32'h02);
		$display("fault test done");
		for (int r = 0; r < 5; r++) begin
			for (int m = 0; m < 3; m++) begin
				wr(tzc_pkg::ADDR_RATE, 32'(r));
				wr(tzc_pkg::ADDR_CONFIG, m == 0 ? 32'h14 : (m == 2 ? 32'h18 : 32'h10));
				one_shot();
				chk({29'h0, tzc_afe_model_i.last_avg[1]}, av(r, m));
				chk({29'h0, tzc_afe_model_i.last_avg[2]}, av(r, m));
			end
		end
		wr(tzc_pkg::ADDR_RATE, 32'h5);
		rd(tzc_pkg::ADDR_RATE, 32'h4);
		$display("averaging test done");
		wr(tzc_pkg::ADDR_RATE, 32'h2);
		wr(tzc_pkg::ADDR_CONFIG, 32'h11);
		wait_sets(3);
		chk(tzc_afe_model_i.int_gap, BP * 4);
		setz(80, 96, 112, 3'h0);
		wait_sets(2);
		zone(tzc_pkg::ADDR_EXT2_HI, nrm(112));
		wr(tzc_pkg::ADDR_RATE, 32'h4);
		wr(tzc_pkg::ADDR_CONFIG, 32'h13);
		for (int i = 0; i < 3; i++) begin
			setz(200, hc[i][0], hc[i][1], 3'h0);
			wait_sets(2);
			zone(tzc_pkg::ADDR_EXT2_HI, nrm(hc[i][2] ? hc[i][0] : hc[i][1]));
			zone(tzc_pkg::ADDR_EXT1_HI, nrm(hc[i][0]));
			apb(1'b0, tzc_pkg::ADDR_STATUS, 32'h0);
			chk({31'h0, q[3]}, 32'(hc[i][2]));
		end
		wr(tzc_pkg::ADDR_CONFIG, 32'h10);
		repeat (200) @(posedge pclk);
		t = tzc_afe_model_i.n_starts;
		repeat (600) @(posedge pclk);
		chk(tzc_afe_model_i.n_starts, t);
		$display("run mode test done");
		close_out();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		failures++;
		close_out();
	end
endmodule

bind tzc_ctrl tzc_ctrl_checker #(.BASE_PERIOD(BASE_PERIOD)) tzc_ctrl_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.afe_req(afe_req), .afe_rsp(afe_rsp));
